// *** src/uart9.sv ***
// Behaviour
// - frame is start, eight data bits lsb first, ninth bit, stop bit
// - transmitted ninth bit comes from tx_ninth_bit in serial_ctrl_reg
// - received ninth bit goes to rx_ninth_bit; stop bit value ignored
// - writing serial_buffer_reg starts sending a new character
// - transmit_done_flag sets at start of the stop-bit time
// - receiver starts a character only while receive-allow is one
// - accept only if rx_full_flag zero and, if filtering, ninth bit one
// - on accept load data, ninth bit, and set rx_full_flag
// - on reject leave buffer, ninth bit and rx_full_flag unchanged
// - interrupt while transmit_done or rx_full set and serial irq enabled; code also masks each flag by its irq_en_ff bit
// - fixed-rate mode divides core_clock by 64, or 32 with doubler
// - baud_doubler resets to zero
// - variable-rate mode times bits from one of two selectable timers
// - mode 3 differs from mode 2 only in baud source
// - baud timer overflow serves baud rate regardless of other timer
// - halting the baud timer stops it; leaving halt restarts it from the new reload
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module uart9 #(
  parameter int TIMER_W = 16
) (
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        RXD_I,
  output var  logic        TXD_O,
  output var  logic        IRQ_O,
  input  wire logic [4:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output var  logic        AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output var  logic        WREADY_O,
  output var  logic [1:0]  BRESP_O,
  output var  logic        BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [4:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output var  logic        ARREADY_O,
  output var  logic [31:0] RDATA_O,
  output var  logic [1:0]  RRESP_O,
  output var  logic        RVALID_O,
  input  wire logic        RREADY_I
);

  initial begin
    if (TIMER_W < 4 || TIMER_W > 16) begin
      $error("TIMER_W out of range");
    end
  end

  localparam int OSW = $clog2(uart9_pkg::OVERSAMPLE);

  // bus write side: address and data latched independently
  logic [4:0]  aw_addr_ff;
  logic        aw_have_ff;
  logic [31:0] w_data_ff;
  logic        w_have_ff;
  logic        bvalid_ff;
  logic [31:0] rdata_ff;
  logic        rvalid_ff;
  logic        arready_ff;

  logic [7:0]  ctrl_ff;
  logic        doubler_ff;
  logic [uart9_pkg::TMR_RELOAD_LSB+TIMER_W-1:0] tmr_ctrl_ff;
  logic [1:0]  irq_en_ff;
  uart9_pkg::char_type rx_buf_ff;
  logic        rx_full_ff;
  logic        tx_done_ff;

  wire do_write = aw_have_ff && w_have_ff && !bvalid_ff;
  wire wr_buf   = do_write && aw_addr_ff == uart9_pkg::ADDR_BUFFER;
  wire wr_ctrl  = do_write && aw_addr_ff == uart9_pkg::ADDR_CTRL;
  wire wr_pwr   = do_write && aw_addr_ff == uart9_pkg::ADDR_POWER;
  wire wr_tmr   = do_write && aw_addr_ff == uart9_pkg::ADDR_TIMER;
  wire wr_en    = do_write && aw_addr_ff == uart9_pkg::ADDR_IRQ_EN;
  wire wr_clr   = do_write && aw_addr_ff == uart9_pkg::ADDR_IRQ_CLR;
  wire wr_known = wr_buf || wr_ctrl || wr_pwr || wr_tmr || wr_en
                  || wr_clr;

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      aw_addr_ff <= 5'h0;
      aw_have_ff <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_have_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
    end else begin
      if (AWVALID_I && !aw_have_ff) begin
        aw_addr_ff <= AWADDR_I;
        aw_have_ff <= 1'b1;
      end
      if (WVALID_I && !w_have_ff) begin
        w_data_ff <= WDATA_I;
        w_have_ff <= 1'b1;
      end
      if (do_write) begin
        bvalid_ff  <= 1'b1;
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
      end else if (bvalid_ff && BREADY_I) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign AWREADY_O = !aw_have_ff;
  assign WREADY_O  = !w_have_ff;
  assign BVALID_O  = bvalid_ff;

  logic [1:0] bresp_ff;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      bresp_ff <= uart9_pkg::RESP_OKAY;
    end else if (do_write) begin
      bresp_ff <= wr_known ? uart9_pkg::RESP_OKAY : uart9_pkg::RESP_SLVERR;
    end
  end
  assign BRESP_O = bresp_ff;

  // software-owned control bits; flags held separately
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl_ff     <= 8'h00;
      doubler_ff  <= 1'b0;
      tmr_ctrl_ff <= '0;
      irq_en_ff   <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= w_data_ff[7:0];
      end
      if (wr_pwr) begin
        doubler_ff <= w_data_ff[uart9_pkg::PWR_DOUBLER];
      end
      if (wr_tmr) begin
        tmr_ctrl_ff <= w_data_ff[uart9_pkg::TMR_RELOAD_LSB+TIMER_W-1:0];
      end
      if (wr_en) begin
        irq_en_ff <= w_data_ff[1:0];
      end
    end
  end

  wire tx_ninth   = ctrl_ff[uart9_pkg::CTRL_TX_NINTH];
  wire rx_allow   = ctrl_ff[uart9_pkg::CTRL_RX_ALLOW];
  wire addr_filt  = ctrl_ff[uart9_pkg::CTRL_ADDR_FILT];
  wire mode3      = ctrl_ff[uart9_pkg::CTRL_MODE3];
  wire serial_ien = ctrl_ff[uart9_pkg::CTRL_IRQ_EN];

  // baud timers: two reload counters, one chosen; halted one holds
  logic [TIMER_W-1:0] tmr_cnt_ff [2];
  logic [1:0]         tmr_ovf;
  wire [TIMER_W-1:0]  reload = tmr_ctrl_ff[uart9_pkg::TMR_RELOAD_LSB +:
                                           TIMER_W];
  wire tmr_sel  = tmr_ctrl_ff[uart9_pkg::TMR_SEL];
  wire tmr_halt = tmr_ctrl_ff[uart9_pkg::TMR_HALT];
  // a timer write restarts both counters from the new reload, so the
  // first overflow after reprogramming is one period away, not 2^W
  wire [TIMER_W-1:0]  new_reload = w_data_ff[uart9_pkg::TMR_RELOAD_LSB +:
                                             TIMER_W];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      wire run = !(tmr_halt && tmr_sel == 1'(g));
      assign tmr_ovf[g] = run && (&tmr_cnt_ff[g]);
      always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
          tmr_cnt_ff[g] <= '0;
        end else if (wr_tmr) begin
          tmr_cnt_ff[g] <= new_reload;
        end else if (tmr_ovf[g]) begin
          tmr_cnt_ff[g] <= reload;
        end else if (run) begin
          tmr_cnt_ff[g] <= tmr_cnt_ff[g] + 1'b1;
        end
      end
    end
  endgenerate

  // the selected timer's overflow feeds the baud path, independent of any flag
  wire var_tick = tmr_ovf[tmr_sel];

  // fixed rate: core clock / (32 or 64) is one bit; 1/16 of that ticks
  localparam int FDIV_W = $clog2(uart9_pkg::FIXED_DIV_SLOW /
                                 uart9_pkg::OVERSAMPLE);
  localparam logic [FDIV_W-1:0] FDIV_SLOW = FDIV_W'(
    uart9_pkg::FIXED_DIV_SLOW / uart9_pkg::OVERSAMPLE - 1);
  localparam logic [FDIV_W-1:0] FDIV_FAST = FDIV_W'(
    uart9_pkg::FIXED_DIV_FAST / uart9_pkg::OVERSAMPLE - 1);
  logic [FDIV_W-1:0] fdiv_ff;
  wire [FDIV_W-1:0] fdiv_top = doubler_ff ? FDIV_FAST : FDIV_SLOW;
  wire fix_tick = fdiv_ff >= fdiv_top;

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      fdiv_ff <= '0;
    end else begin
      fdiv_ff <= fix_tick ? '0 : fdiv_ff + 1'b1;
    end
  end

  // only the rate source depends on mode 3
  wire os_tick = mode3 ? var_tick : fix_tick;

  // transmitter
  logic [OSW-1:0] tx_os_ff;
  logic [3:0]     tx_bit_ff;
  logic [10:0]    tx_shift_ff;
  logic           tx_busy_ff;
  logic           txd_ff;
  wire tx_bit_end = os_tick && (&tx_os_ff);
  wire tx_last    = tx_bit_ff == 4'(uart9_pkg::FRAME_BITS - 1);
  wire stop_begin = tx_busy_ff && tx_bit_end
                    && tx_bit_ff == 4'(uart9_pkg::FRAME_BITS - 2);

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tx_os_ff    <= '0;
      tx_bit_ff   <= 4'h0;
      tx_shift_ff <= '1;
      tx_busy_ff  <= 1'b0;
      txd_ff      <= 1'b1;
    end else if (wr_buf) begin
      // a write restarts the frame, even mid-character
      tx_shift_ff <= {1'b1, tx_ninth, w_data_ff[7:0], 1'b0};
      tx_busy_ff  <= 1'b1;
      tx_os_ff    <= '0;
      tx_bit_ff   <= 4'h0;
      txd_ff      <= 1'b0;
    end else if (tx_busy_ff && os_tick) begin
      tx_os_ff <= tx_os_ff + 1'b1;
      if (tx_bit_end) begin
        if (tx_last) begin
          tx_busy_ff <= 1'b0;
          txd_ff     <= 1'b1;
        end else begin
          tx_bit_ff   <= tx_bit_ff + 1'b1;
          tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
          txd_ff      <= tx_shift_ff[1];
        end
      end
    end
  end
  assign TXD_O = txd_ff;

  // receiver
  uart9_pkg::rx_state_type rx_st_ff;
  logic [OSW-1:0] rx_os_ff;
  logic [3:0]     rx_bit_ff;
  logic [8:0]     rx_shift_ff;
  logic           rxd_prev_ff;
  localparam logic [OSW-1:0] MID = OSW'(uart9_pkg::OVERSAMPLE / 2 - 1);
  wire rx_mid   = os_tick && rx_os_ff == MID;
  wire rx_fall  = rxd_prev_ff && !RXD_I;
  wire rx_done  = rx_st_ff == uart9_pkg::RX_SHIFT && rx_mid
                  && rx_bit_ff == 4'(uart9_pkg::FRAME_BITS - 2);
  // stop bit not checked; decision made at its sample point
  wire rx_ninth = rx_shift_ff[8];
  wire accept   = rx_done && !rx_full_ff
                  && (!addr_filt || rx_ninth);

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rx_st_ff    <= uart9_pkg::RX_IDLE;
      rx_os_ff    <= '0;
      rx_bit_ff   <= 4'h0;
      rx_shift_ff <= '0;
      rxd_prev_ff <= 1'b1;
    end else begin
      rxd_prev_ff <= RXD_I;
      if (os_tick) begin
        rx_os_ff <= rx_os_ff + 1'b1;
      end
      case (rx_st_ff)
        uart9_pkg::RX_IDLE: begin
          if (rx_allow && rx_fall) begin
            rx_st_ff <= uart9_pkg::RX_START;
            rx_os_ff <= '0;
          end
        end
        uart9_pkg::RX_START: begin
          if (rx_mid) begin
            rx_st_ff  <= RXD_I ? uart9_pkg::RX_IDLE : uart9_pkg::RX_SHIFT;
            rx_bit_ff <= 4'h0;
          end
        end
        uart9_pkg::RX_SHIFT: begin
          if (rx_mid) begin
            rx_bit_ff <= rx_bit_ff + 1'b1;
            if (rx_bit_ff < 4'(uart9_pkg::FRAME_BITS - 2)) begin
              rx_shift_ff <= {RXD_I, rx_shift_ff[8:1]};
            end else begin
              rx_st_ff <= uart9_pkg::RX_IDLE;
            end
          end
        end
        default: rx_st_ff <= uart9_pkg::RX_IDLE;
      endcase
    end
  end

  // flags: hardware sets, software clears; set wins
  wire clr_ctrl_rx = wr_ctrl && !w_data_ff[uart9_pkg::CTRL_RX_FULL];
  wire clr_ctrl_tx = wr_ctrl && !w_data_ff[uart9_pkg::CTRL_TX_DONE];
  wire clr_rx = clr_ctrl_rx
                || (wr_clr && w_data_ff[uart9_pkg::CTRL_RX_FULL]);
  wire clr_tx = clr_ctrl_tx
                || (wr_clr && w_data_ff[uart9_pkg::CTRL_TX_DONE]);

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rx_buf_ff  <= '0;
      rx_full_ff <= 1'b0;
      tx_done_ff <= 1'b0;
    end else begin
      if (accept) begin
        rx_buf_ff <= '{data: rx_shift_ff[7:0], ninth: rx_ninth};
        rx_full_ff <= 1'b1;
      end else if (clr_rx) begin
        rx_full_ff <= 1'b0;
      end
      if (stop_begin) begin
        tx_done_ff <= 1'b1;
      end else if (clr_tx) begin
        tx_done_ff <= 1'b0;
      end
    end
  end

  wire [1:0] flags = {tx_done_ff, rx_full_ff};
  logic irq_ff;
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= serial_ien && |(flags & irq_en_ff);
    end
  end
  assign IRQ_O = irq_ff;

  // read side: one read at a time, answer one cycle after address
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ARADDR_I)
      uart9_pkg::ADDR_BUFFER: rd_mux = {24'h00_0000, rx_buf_ff.data};
      uart9_pkg::ADDR_CTRL: begin
        rd_mux = {24'h00_0000, ctrl_ff};
        rd_mux[uart9_pkg::CTRL_RX_FULL]  = rx_full_ff;
        rd_mux[uart9_pkg::CTRL_TX_DONE]  = tx_done_ff;
        rd_mux[uart9_pkg::CTRL_RX_NINTH] = rx_buf_ff.ninth;
      end
      uart9_pkg::ADDR_POWER: rd_mux[uart9_pkg::PWR_DOUBLER] = doubler_ff;
      uart9_pkg::ADDR_TIMER: rd_mux = 32'(tmr_ctrl_ff);
      uart9_pkg::ADDR_IRQ_ST: rd_mux = {30'h0000_0000, flags};
      uart9_pkg::ADDR_IRQ_EN: rd_mux = {30'h0000_0000, irq_en_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  wire rd_known = ARADDR_I <= uart9_pkg::ADDR_IRQ_EN
                  && ARADDR_I[1:0] == 2'h0;
  logic [1:0] rresp_ff;

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_ff     <= 32'h0000_0000;
      rvalid_ff    <= 1'b0;
      arready_ff   <= 1'b1;
      rresp_ff     <= uart9_pkg::RESP_OKAY;
    end else if (ARVALID_I && arready_ff) begin
      rdata_ff     <= rd_mux;
      rresp_ff     <= rd_known ? uart9_pkg::RESP_OKAY
                               : uart9_pkg::RESP_SLVERR;
      rvalid_ff    <= 1'b1;
      arready_ff   <= 1'b0;
    end else if (rvalid_ff && RREADY_I) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end
  assign ARREADY_O = arready_ff;
  assign RDATA_O   = rdata_ff;
  assign RVALID_O  = rvalid_ff;
  assign RRESP_O   = rresp_ff;

  // assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  tx_start_low_a: assert property (wr_buf |=> !TXD_O)
    else $error("start bit not driven low");
  tx_ninth_a: assert property (wr_buf |=>
      tx_shift_ff[uart9_pkg::FRAME_BITS - 2] == $past(tx_ninth))
    else $error("ninth bit mismatch");
  tx_done_set_a: assert property (stop_begin |=> tx_done_ff)
    else $error("transmit done not set");
  rx_accept_a: assert property (accept |=> rx_full_ff
      && rx_buf_ff.data == $past(rx_shift_ff[7:0]))
    else $error("character not loaded");
  rx_reject_a: assert property (rx_done && !accept && !clr_rx
      |=> $stable(rx_buf_ff) && rx_full_ff == $past(rx_full_ff))
    else $error("rejected character changed state");
  rx_filter_a: assert property (accept |-> !addr_filt || rx_ninth)
    else $error("filter bypassed");
  rx_allow_a: assert property (rx_st_ff == uart9_pkg::RX_IDLE && !rx_allow
      |=> rx_st_ff == uart9_pkg::RX_IDLE)
    else $error("receiver started while disallowed");
  irq_level_a: assert property (##1 IRQ_O == $past(serial_ien
      && |(flags & irq_en_ff)))
    else $error("interrupt mismatch");
  flag_hold_a: assert property (rx_full_ff && !clr_rx |=> rx_full_ff)
    else $error("rx full cleared by hardware");

  tx_cov: cover property (stop_begin);
  rx_cov: cover property (accept);
  rej_cov: cover property (rx_done && !accept);
  mode3_cov: cover property (mode3 && accept);

endmodule // uart9
`default_nettype wire

// *** src/uart9_pkg.sv ***
package uart9_pkg;

  // register byte addresses on the axi4-lite bus
  localparam logic [4:0] ADDR_BUFFER  = 5'h00;
  localparam logic [4:0] ADDR_CTRL    = 5'h04;
  localparam logic [4:0] ADDR_POWER   = 5'h08;
  localparam logic [4:0] ADDR_TIMER   = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_ST  = 5'h10;
  localparam logic [4:0] ADDR_IRQ_EN  = 5'h14;
  localparam logic [4:0] ADDR_IRQ_CLR = 5'h18;

  // serial control field positions
  localparam int CTRL_RX_FULL   = 0;
  localparam int CTRL_TX_DONE   = 1;
  localparam int CTRL_RX_NINTH  = 2;
  localparam int CTRL_TX_NINTH  = 3;
  localparam int CTRL_RX_ALLOW  = 4;
  localparam int CTRL_ADDR_FILT = 5;
  localparam int CTRL_MODE3     = 6;
  localparam int CTRL_IRQ_EN    = 7;
  localparam int PWR_DOUBLER    = 7;

  // baud timer control field positions
  localparam int TMR_SEL        = 0;
  localparam int TMR_HALT       = 1;
  localparam int TMR_RELOAD_LSB = 8;

  localparam int FRAME_BITS     = 11;
  localparam int OVERSAMPLE     = 16;
  localparam int FIXED_DIV_SLOW = 64;
  localparam int FIXED_DIV_FAST = 32;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
  } char_type;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_SHIFT
  } rx_state_type;

endpackage

// *** verif/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, v;
  wire  logic  rxd, txd, irq, awready, wready, bvalid, arready, rvalid;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata;
  int          err_total, checks, cyc, t_fall, t_irq;
  logic        txd_q, irq_q, m_nin, m_full, m_any, ien, m3, filt, allow, txn;
  logic [7:0]  m_buf;
  logic [1:0]  r;

  uart9 dut (.CLK_I(clk), .RESET_I(rst), .RXD_I(rxd), .TXD_O(txd),
    .IRQ_O(irq), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
    .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
    .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready));
  uart_peer peer (.clk_i(clk), .line_i(txd), .line_o(rxd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // first start edge and first interrupt rise, for bit-time figures
  always @(posedge clk) begin
    cyc <= cyc + 1;
    txd_q <= txd;
    irq_q <= irq;
    if (txd_q === 1'b1 && txd === 1'b0 && t_fall < 0) t_fall <= cyc;
    if (irq_q === 1'b0 && irq === 1'b1 && t_irq < 0) t_irq <= cyc;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // bready and rready stay high, so only the request side moves
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 200);
    r = bresp;
    if (n >= 200) begin
      err_total++;
      conclude();
    end
  endtask

  task automatic axi_rd(input logic [4:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 200);
    v = rdata;
    r = rresp;
    if (n >= 200) begin
      err_total++;
      conclude();
    end
  endtask

  function automatic logic [31:0] ctl_word();
    return {24'h0, ien, m3, filt, allow, txn, 3'b011};
  endfunction

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask

  task automatic tx_frame(input int bitc);
    logic [7:0] d, gd;
    logic       gn, gs, ok;
    d = 8'($urandom);
    t_fall = -1;
    t_irq = -1;
    axi_wr(uart9_pkg::ADDR_BUFFER, {24'h0, d});
    peer.recv(bitc, gd, gn, gs, ok);
    cmp_flag(ok, 1'b1);
    cmp_word({24'h0, gd}, {24'h0, d});
    cmp_flag(gn, txn);
    cmp_flag(gs, 1'b1);
    // the rate divider free-runs, so the start bit may lose up to a tick
    cmp_flag((t_irq - t_fall) inside {[10*bitc-2:10*bitc+1]},
             1'b1);
    axi_rd(uart9_pkg::ADDR_IRQ_ST);
    cmp_word(v & 32'h0000_0003, 32'h0000_0002);
    axi_wr(uart9_pkg::ADDR_IRQ_CLR, 32'h0000_0002);
    // the interrupt is registered: it drops one edge after the flag
    @(posedge clk);
    cmp_flag(irq, 1'b0);
  endtask

  // bench model of the acceptance rule, compared after every frame
  task automatic rx_frame(input logic [7:0] d, input logic n, input logic s);
    peer.send(d, n, s, 64);
    if (allow && !m_full && (!filt || n)) begin
      m_buf = d;
      m_nin = n;
      m_full = 1'b1;
      m_any = 1'b1;
    end
    axi_rd(uart9_pkg::ADDR_CTRL);
    cmp_flag(v[0], m_full);
    cmp_flag(v[2], m_nin);
    if (m_any) begin
      axi_rd(uart9_pkg::ADDR_BUFFER);
      cmp_word(v & 32'h0000_00FF, {24'h0, m_buf});
    end
    cmp_flag(irq, ien & m_full);
  endtask

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready, txd_q} = 3'b111;
    {irq_q, m_nin, m_full, m_any, ien, m3, filt, allow, txn} = '0;
    {err_total, checks, cyc, t_fall, t_irq} = '0;
    m_buf = 8'h00;
    void'($urandom(32'hde5a));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_rd(uart9_pkg::ADDR_CTRL);
    cmp_word(v & 32'h0000_00FF, 32'h0000_0000);
    axi_rd(uart9_pkg::ADDR_POWER);
    cmp_flag(v[uart9_pkg::PWR_DOUBLER], 1'b0);
    cmp_flag(txd, 1'b1);
    axi_rd(5'h1C);
    cmp_word({30'h0, r}, {30'h0, uart9_pkg::RESP_SLVERR});
    axi_wr(5'h1C, 32'h0000_00FF);
    cmp_word({30'h0, r}, {30'h0, uart9_pkg::RESP_SLVERR});
    end_test("reset");
    ien = 1'b1;
    axi_wr(uart9_pkg::ADDR_IRQ_EN, 32'h0000_0002);
    for (int dbl = 0; dbl < 2; dbl++) begin
      txn = 1'($urandom);
      axi_wr(uart9_pkg::ADDR_POWER, 32'(dbl) << 7);
      axi_wr(uart9_pkg::ADDR_CTRL, ctl_word());
      tx_frame(64 >> dbl);
    end
    end_test("fixed rate");
    m3 = 1'b1;
    axi_wr(uart9_pkg::ADDR_POWER, 32'h0000_0000);
    for (int sel = 0; sel < 2; sel++) begin
      txn = 1'($urandom);
      axi_wr(uart9_pkg::ADDR_TIMER,
             {8'h0, (sel == 1) ? 16'hFFFE : 16'hFFFC, 7'h0, 1'(sel)});
      axi_wr(uart9_pkg::ADDR_CTRL, ctl_word());
      tx_frame((sel == 1) ? 32 : 64);
    end
    // a halted timer must freeze the frame well past its normal length
    axi_wr(uart9_pkg::ADDR_TIMER, {8'h0, 16'hFFFE, 8'h03});
    axi_wr(uart9_pkg::ADDR_BUFFER, 32'h0000_005A);
    repeat (800) @(posedge clk);
    axi_rd(uart9_pkg::ADDR_IRQ_ST);
    cmp_flag(v[1], 1'b0);
    axi_wr(uart9_pkg::ADDR_TIMER, {8'h0, 16'hFFFE, 8'h01});
    for (int i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge clk);
    cmp_flag(irq, 1'b1);
    axi_wr(uart9_pkg::ADDR_IRQ_CLR, 32'h0000_0003);
    end_test("timer rate");
    m3 = 1'b0;
    axi_wr(uart9_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    axi_wr(uart9_pkg::ADDR_CTRL, ctl_word());
    rx_frame(8'($urandom), 1'b1, 1'b1);
    allow = 1'b1;
    axi_wr(uart9_pkg::ADDR_CTRL, ctl_word());
    rx_frame(8'($urandom), 1'($urandom), 1'b0);
    axi_wr(uart9_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    @(posedge clk);
    cmp_flag(irq, 1'b0);
    axi_wr(uart9_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    rx_frame(8'($urandom), 1'b1, 1'b1);
    axi_wr(uart9_pkg::ADDR_CTRL, ctl_word() & 32'hFFFF_FFFE);
    m_full = 1'b0;
    filt = 1'b1;
    axi_wr(uart9_pkg::ADDR_CTRL, ctl_word());
    rx_frame(8'($urandom), 1'b0, 1'b1);
    rx_frame(8'($urandom), 1'b1, 1'b1);
    end_test("receive");
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule // tb
`default_nettype wire

// *** verif/uart_peer.sv ***
`timescale 1ns/1ns
`default_nettype none
module uart_peer (
  input  wire logic clk_i,
  input  wire logic line_i,
  output var  logic line_o
);
  initial line_o = 1'b1;

  // enter right after a rising edge; every bit is driven on a clock edge
  task automatic send(input logic [7:0] d, input logic n, input logic stp,
                      input int bit_clks);
    logic [10:0] frame;
    frame = {stp, n, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o <= frame[i];
      repeat (bit_clks) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask

  // samples mid-bit from the first low seen; returns in the stop bit
  task automatic recv(input int bit_clks, output logic [7:0] d,
                      output logic n, output logic stp, output logic ok);
    logic [10:0] f;
    int          w;
    w = 0;
    f = '1;
    while (line_i !== 1'b0 && w < 4000) begin
      @(posedge clk_i);
      w++;
    end
    repeat (bit_clks / 2) @(posedge clk_i);
    for (int i = 0; i < 11; i++) begin
      f[i] = line_i;
      if (i < 10) repeat (bit_clks) @(posedge clk_i);
    end
    d = f[8:1];
    n = f[9];
    stp = f[10];
    ok = (w < 4000) && (f[0] === 1'b0);
  endtask
endmodule // uart_peer
`default_nettype wire
